// ===== hw/ipr_bank.sv
// priority register bank for six interrupt-priority registers on wishbone
//
// Functional notes
// - three-bit fields, binary level, seven highest
// - level zero disables its source entirely
// - unimplemented bits always read zero
// - every field resets to level four
// - reg a: timer6 level at 14-12
// - reg a: dma channel 4 at 10-8
// - reg a: compare8 at 2-0, 7-3 empty
// - reg b: timer8 level at 14-12
// - reg b: i2c2 master at 10-8
// - reg b: i2c2 slave at 6-4
// - reg b: timer7 level at 2-0
// - reg c: can2 receive at 14-12
// - reg c: ext4 at 10-8, ext3 6-4
// - reg c: timer9 level at 2-0
// - reg d: can2 event at 2-0
// - reg e: dma channel 5 at 6-4
// - reg f: uart2 10-8, uart1 6-4
//
// The Wishbone interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ipr_defines.svh"
module ipr_bank (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // raw source requests from peripherals, same clock
  input wire ipr_pkg::ipr_src_type src_req,
  // levels and enabled requests to the arbitration logic
  output ipr_pkg::ipr_levels_type levels,
  output ipr_pkg::ipr_src_type src_pending
);
  import ipr_pkg::*;

  // register index decoded from the address
  logic [5:0] hit;
  // stored register images
  logic [15:0] reg_val [6];
  // write strobe per register
  logic [5:0] wr_en;
  // bus phase
  ipr_state_type state_r;
  ipr_state_type state_nxt;
  // registered read data and error flag
  logic [31:0] rdata_r;
  logic err_r;
  // mapped and request conditions
  logic req;
  logic mapped;

  ////////////////////////////////////////////////////////////////////////////
  // extract the field whose low bit sits at pos
  function automatic ipr_level_type fld(input logic [15:0] v, input int pos);
    fld = v[pos +: `IPR_FIELD_W];
  endfunction : fld

  // one-hot register decode; lower two address bits ignored
  function automatic logic [5:0] decode(input logic [7:0] adr);
    logic [7:0] a;
    a = {adr[7:2], 2'b00};
    decode = 6'h00;
    case (a)
      `IPR_OFF_REG_A: decode = 6'h01;
      `IPR_OFF_REG_B: decode = 6'h02;
      `IPR_OFF_REG_C: decode = 6'h04;
      `IPR_OFF_REG_D: decode = 6'h08;
      `IPR_OFF_REG_E: decode = 6'h10;
      `IPR_OFF_REG_F: decode = 6'h20;
      default: decode = 6'h00;
    endcase
  endfunction : decode

  ////////////////////////////////////////////////////////////////////////////
  // request is taken only in idle, so ack lasts exactly one cycle
  assign req = wb_cyc_i && wb_stb_i && (state_r == IPR_IDLE);
  assign hit = decode(wb_adr_i);
  assign mapped = |hit;
  // writes land at the edge that takes the request, ack comes one cycle later
  assign wr_en = (req && wb_we_i) ? hit : 6'h00;

  // six registers share one module; masks fix the field layout
  ipr_reg16 #(.MASK(`IPR_MASK_A), .RST(`IPR_RST_A)) u_reg_a (
    .core_clk(core_clk), .rstn(rstn), .wr_en(wr_en[0]),
    .wr_data(wb_dat_i[15:0]), .wr_sel(wb_sel_i[1:0]), .value(reg_val[0]));
  ipr_reg16 #(.MASK(`IPR_MASK_B), .RST(`IPR_RST_B)) u_reg_b (
    .core_clk(core_clk), .rstn(rstn), .wr_en(wr_en[1]),
    .wr_data(wb_dat_i[15:0]), .wr_sel(wb_sel_i[1:0]), .value(reg_val[1]));
  ipr_reg16 #(.MASK(`IPR_MASK_C), .RST(`IPR_RST_C)) u_reg_c (
    .core_clk(core_clk), .rstn(rstn), .wr_en(wr_en[2]),
    .wr_data(wb_dat_i[15:0]), .wr_sel(wb_sel_i[1:0]), .value(reg_val[2]));
  ipr_reg16 #(.MASK(`IPR_MASK_D), .RST(`IPR_RST_D)) u_reg_d (
    .core_clk(core_clk), .rstn(rstn), .wr_en(wr_en[3]),
    .wr_data(wb_dat_i[15:0]), .wr_sel(wb_sel_i[1:0]), .value(reg_val[3]));
  ipr_reg16 #(.MASK(`IPR_MASK_E), .RST(`IPR_RST_E)) u_reg_e (
    .core_clk(core_clk), .rstn(rstn), .wr_en(wr_en[4]),
    .wr_data(wb_dat_i[15:0]), .wr_sel(wb_sel_i[1:0]), .value(reg_val[4]));
  ipr_reg16 #(.MASK(`IPR_MASK_F), .RST(`IPR_RST_F)) u_reg_f (
    .core_clk(core_clk), .rstn(rstn), .wr_en(wr_en[5]),
    .wr_data(wb_dat_i[15:0]), .wr_sel(wb_sel_i[1:0]), .value(reg_val[5]));

  ////////////////////////////////////////////////////////////////////////////
  // bus phase: idle takes a request, ack answers it for one cycle
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      IPR_IDLE: begin
        if (req) begin
          state_nxt = IPR_ACK;
        end
      end
      IPR_ACK: state_nxt = IPR_IDLE;
      default: state_nxt = IPR_IDLE;
    endcase
  end

  // phase register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= IPR_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // read data captured with the request; upper half always zero
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      rdata_r <= 32'h0000_0000;
      for (int i = 0; i < 6; i++) begin
        if (hit[i]) begin
          rdata_r <= {16'h0000, reg_val[i]};
        end
      end
    end
  end

  // unmapped addresses answer with err instead of ack
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      err_r <= 1'b0;
    end else if (req) begin
      err_r <= !mapped;
    end
  end

  assign wb_ack_o = (state_r == IPR_ACK) && !err_r;
  assign wb_err_o = (state_r == IPR_ACK) && err_r;
  assign wb_dat_o = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // field placement toward the arbitration logic
  always_comb begin
    levels.timer6_level = fld(reg_val[0], `IPR_POS_HI);
    levels.dma_ch4_level = fld(reg_val[0], `IPR_POS_MH);
    levels.compare8_level = fld(reg_val[0], `IPR_POS_LO);
    levels.timer8_level = fld(reg_val[1], `IPR_POS_HI);
    levels.i2c2_master_level = fld(reg_val[1], `IPR_POS_MH);
    levels.i2c2_slave_level = fld(reg_val[1], `IPR_POS_ML);
    levels.timer7_level = fld(reg_val[1], `IPR_POS_LO);
    levels.can2_receive_level = fld(reg_val[2], `IPR_POS_HI);
    levels.ext_irq4_level = fld(reg_val[2], `IPR_POS_MH);
    levels.ext_irq3_level = fld(reg_val[2], `IPR_POS_ML);
    levels.timer9_level = fld(reg_val[2], `IPR_POS_LO);
    levels.can2_event_level = fld(reg_val[3], `IPR_POS_LO);
    levels.dma_ch5_level = fld(reg_val[4], `IPR_POS_ML);
    levels.uart2_error_level = fld(reg_val[5], `IPR_POS_MH);
    levels.uart1_error_level = fld(reg_val[5], `IPR_POS_ML);
  end

  // a source at level zero never reaches the cpu; combinational so a
  // level change acts in the same cycle the register shows it
  always_comb begin
    for (int i = 0; i < 15; i++) begin
      src_pending[i] = src_req[i] && (levels[i*3 +: 3] != `IPR_LEVEL_OFF);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_ack_one_cycle: assert property (@(posedge core_clk) disable iff (!rstn)
    wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
  chk_write_visible: assert property (@(posedge core_clk) disable iff (!rstn)
    (req && wb_we_i && hit[0] && (wb_sel_i[1:0] == 2'b11)) |=>
      (levels.timer6_level == $past(wb_dat_i[14:12])) && wb_ack_o)
    else $error("write to reg a not visible next cycle");
  chk_disabled_src: assert property (@(posedge core_clk) disable iff (!rstn)
    (levels.can2_event_level == `IPR_LEVEL_OFF) |-> !src_pending[3])
    else $error("disabled source presented");
  chk_enabled_src: assert property (@(posedge core_clk) disable iff (!rstn)
    (src_req[10] && levels.i2c2_master_level != `IPR_LEVEL_OFF) |-> src_pending[10])
    else $error("enabled source dropped");
  chk_read_upper: assert property (@(posedge core_clk) disable iff (!rstn)
    wb_ack_o |-> (wb_dat_o[31:16] == 16'h0000)) else $error("upper read bits set");
  chk_read_reg_f: assert property (@(posedge core_clk) disable iff (!rstn)
    (req && !wb_we_i && hit[5]) |=> (wb_dat_o[15:0] ==
      {5'h00, $past(levels.uart2_error_level), 1'b0, $past(levels.uart1_error_level), 4'h0}))
    else $error("reg f read layout wrong");
  chk_read_reg_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (req && !wb_we_i && hit[0]) |=> (wb_dat_o[7:3] == 5'h00) &&
      (wb_dat_o[2:0] == $past(levels.compare8_level)))
    else $error("reg a low byte layout wrong");
  chk_reset_level: assert property (@(posedge core_clk)
    $rose(rstn) |-> (levels.can2_event_level == `IPR_LEVEL_RST) &&
      (levels.dma_ch5_level == `IPR_LEVEL_RST)) else $error("reset level not four");
  chk_err_unmapped: assert property (@(posedge core_clk) disable iff (!rstn)
    (req && !mapped) |=> wb_err_o && !wb_ack_o) else $error("unmapped access acked");

  ////////////////////////////////////////////////////////////////////////////
  // read layout: the captured word must match the levels that stood when the
  // request was taken, with every unimplemented bit low
  chk_read_reg_a_hi: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (req && !wb_we_i && hit[0]) |=> (wb_dat_o[15:8] ==
      {1'b0, $past(levels.timer6_level), 1'b0, $past(levels.dma_ch4_level)}))
    else $error("reg a high byte layout wrong");

  // reg b packs four fields, each with a zero gap above it
  chk_read_reg_b: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (req && !wb_we_i && hit[1]) |=> (wb_dat_o[15:0] ==
      {1'b0, $past(levels.timer8_level), 1'b0, $past(levels.i2c2_master_level),
      1'b0, $past(levels.i2c2_slave_level), 1'b0, $past(levels.timer7_level)}))
    else $error("reg b read layout wrong");

  // reg c has the same four-field shape as reg b
  chk_read_reg_c: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (req && !wb_we_i && hit[2]) |=> (wb_dat_o[15:0] ==
      {1'b0, $past(levels.can2_receive_level), 1'b0, $past(levels.ext_irq4_level),
      1'b0, $past(levels.ext_irq3_level), 1'b0, $past(levels.timer9_level)}))
    else $error("reg c read layout wrong");

  // reg d holds one field in its lowest bits
  chk_read_reg_d: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (req && !wb_we_i && hit[3]) |=> (wb_dat_o[15:0] ==
      {13'h0000, $past(levels.can2_event_level)}))
    else $error("reg d read layout wrong");

  // reg e holds one field in the middle of its low byte
  chk_read_reg_e: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (req && !wb_we_i && hit[4]) |=> (wb_dat_o[15:0] ==
      {9'h000, $past(levels.dma_ch5_level), 4'h0}))
    else $error("reg e read layout wrong");

  // an unmapped read answers with a zero word rather than stale data
  chk_read_unmapped: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (req && !wb_we_i && !mapped) |=> (wb_dat_o == 32'h0000_0000))
    else $error("unmapped read not zero");

  ////////////////////////////////////////////////////////////////////////////
  // write path: a full-word write shows bit for bit in the levels one cycle
  // later; the binary value is passed on without any recoding
  chk_write_reg_c: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (req && wb_we_i && hit[2] && (wb_sel_i[1:0] == 2'b11)) |=>
      (levels.can2_receive_level == $past(wb_dat_i[14:12])) &&
      (levels.ext_irq4_level == $past(wb_dat_i[10:8])) &&
      (levels.ext_irq3_level == $past(wb_dat_i[6:4])) &&
      (levels.timer9_level == $past(wb_dat_i[2:0])))
    else $error("write to reg c not visible next cycle");

  // reg d only needs its low lane
  chk_write_reg_d: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (req && wb_we_i && hit[3] && wb_sel_i[0]) |=>
      (levels.can2_event_level == $past(wb_dat_i[2:0])))
    else $error("write to reg d not visible next cycle");

  // reg e only needs its low lane as well
  chk_write_reg_e: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (req && wb_we_i && hit[4] && wb_sel_i[0]) |=>
      (levels.dma_ch5_level == $past(wb_dat_i[6:4])))
    else $error("write to reg e not visible next cycle");

  // reg f spreads its two fields over both lanes
  chk_write_reg_f: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (req && wb_we_i && hit[5] && (wb_sel_i[1:0] == 2'b11)) |=>
      (levels.uart2_error_level == $past(wb_dat_i[10:8])) &&
      (levels.uart1_error_level == $past(wb_dat_i[6:4])))
    else $error("write to reg f not visible next cycle");

  // a write on the low lane alone leaves the upper fields of reg b alone
  chk_lane_keep: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (req && wb_we_i && hit[1] && (wb_sel_i[1:0] == 2'b01)) |=>
      $stable(levels.timer8_level) && $stable(levels.i2c2_master_level))
    else $error("low lane write disturbed upper fields");

  // a read must never disturb a stored level
  chk_read_no_write: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (req && !wb_we_i) |=> $stable(levels))
    else $error("read changed a level");

  // a write to a hole in the map is dropped whole
  chk_err_no_write: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (req && !mapped) |=> $stable(levels))
    else $error("unmapped write changed a level");

  ////////////////////////////////////////////////////////////////////////////
  // handshake: one answer per taken request, none without one, and the read
  // word holds between reads so a slow master still sees it
  chk_answer_follows: assert property (
    @(posedge core_clk) disable iff (!rstn)
    req |=> (wb_ack_o || wb_err_o))
    else $error("taken request not answered");

  // no answer in a cycle that did not follow a taken request
  chk_no_stray_answer: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !$past(req) |-> (!wb_ack_o && !wb_err_o))
    else $error("answer without a request");

  // read data only moves at the edge that takes a read
  chk_dat_hold: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !($past(req) && !$past(wb_we_i)) |-> $stable(wb_dat_o))
    else $error("read data moved without a read");

  ////////////////////////////////////////////////////////////////////////////
  // gating: nothing is presented that its peripheral has not raised
  chk_pending_needs_req: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (src_pending & ~src_req) == 15'h0000)
    else $error("pending without a request");

  // every field of every register comes out of reset at level four
  chk_reset_all: assert property (
    @(posedge core_clk)
    $rose(rstn) |-> (levels == {15{`IPR_LEVEL_RST}}))
    else $error("some level not four after reset");

  // while reset is held the bus stays quiet; the first edge of a reset is
  // skipped since the flops may not have seen it yet
  chk_reset_quiet: assert property (
    @(posedge core_clk)
    (!rstn && !$past(rstn)) |->
      (!wb_ack_o && !wb_err_o && (wb_dat_o == 32'h0000_0000)))
    else $error("bus active during reset");
endmodule : ipr_bank
`default_nettype wire

// ===== hw/ipr_defines.svh
// register offsets, field positions and reset values of the priority bank
`ifndef IPR_DEFINES_SVH
`define IPR_DEFINES_SVH
// byte offsets of the six priority registers on the bus
`define IPR_OFF_REG_A 8'h00
`define IPR_OFF_REG_B 8'h04
`define IPR_OFF_REG_C 8'h08
`define IPR_OFF_REG_D 8'h0c
`define IPR_OFF_REG_E 8'h10
`define IPR_OFF_REG_F 8'h14
// low bit of each 3-bit field position inside a 16-bit register
`define IPR_POS_HI 12
`define IPR_POS_MH 8
`define IPR_POS_ML 4
`define IPR_POS_LO 0
// field width and reset level
`define IPR_FIELD_W 3
`define IPR_LEVEL_RST 3'h4
`define IPR_LEVEL_OFF 3'h0
// implemented-bit masks of each register
`define IPR_MASK_A 16'h7707
`define IPR_MASK_B 16'h7777
`define IPR_MASK_C 16'h7777
`define IPR_MASK_D 16'h0007
`define IPR_MASK_E 16'h0070
`define IPR_MASK_F 16'h0770
// reset value of each register
`define IPR_RST_A 16'h4404
`define IPR_RST_B 16'h4444
`define IPR_RST_C 16'h4444
`define IPR_RST_D 16'h0004
`define IPR_RST_E 16'h0040
`define IPR_RST_F 16'h0440
`endif

// ===== hw/ipr_pkg.sv
// types shared by the priority register bank
`default_nettype none
package ipr_pkg;
  // one 3-bit priority level
  typedef logic [2:0] ipr_level_type;
  // levels delivered to the arbitration logic
  typedef struct packed {
    ipr_level_type timer6_level;
    ipr_level_type dma_ch4_level;
    ipr_level_type compare8_level;
    ipr_level_type timer8_level;
    ipr_level_type i2c2_master_level;
    ipr_level_type i2c2_slave_level;
    ipr_level_type timer7_level;
    ipr_level_type can2_receive_level;
    ipr_level_type ext_irq4_level;
    ipr_level_type ext_irq3_level;
    ipr_level_type timer9_level;
    ipr_level_type can2_event_level;
    ipr_level_type dma_ch5_level;
    ipr_level_type uart2_error_level;
    ipr_level_type uart1_error_level;
  } ipr_levels_type;
  // raw requests and the gated, enabled view
  typedef logic [14:0] ipr_src_type;
  // bus slave phases
  typedef enum logic [1:0] {
    IPR_IDLE = 2'b01,
    IPR_ACK = 2'b10
  } ipr_state_type;
endpackage : ipr_pkg
`default_nettype wire

// ===== hw/ipr_reg16.sv
// one 16-bit priority register with a fixed implemented-bit mask
`timescale 1ns/1ps
`default_nettype none
module ipr_reg16 #(
  parameter logic [15:0] MASK = 16'h0000,
  parameter logic [15:0] RST = 16'h0000
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // write port
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  input wire logic [1:0] wr_sel,
  // stored value, unimplemented bits zero
  output logic [15:0] value
);
  logic [15:0] value_r;
  logic [15:0] value_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // byte lanes merge; masking here keeps unimplemented flops constant zero
  always_comb begin
    value_nxt = value_r;
    if (wr_sel[0]) begin
      value_nxt[7:0] = wr_data[7:0];
    end
    if (wr_sel[1]) begin
      value_nxt[15:8] = wr_data[15:8];
    end
    value_nxt = value_nxt & MASK;
  end

  // storage, reset to level four in every field
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      value_r <= RST;
    end else if (wr_en) begin
      value_r <= value_nxt;
    end
  end

  assign value = value_r & MASK;

  // unimplemented bits can never appear
  chk_unimpl_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    (value & ~MASK) == 16'h0000) else $error("unimplemented bits set");
endmodule : ipr_reg16
`default_nettype wire

// ===== tb/ipr_bank_test.sv
// self-checking bench for the priority register bank
`timescale 1ns/1ps
`default_nettype none
module ipr_bank_test;
  import ipr_pkg::*;
  logic core_clk, rstn, cyc, stb, we, ack, err, gerr;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [3:0] lanes; // byte lanes the next transfer uses
  logic [31:0] wdat, rdat;
  logic [15:0] got;
  ipr_src_type pattern, src_req, pend;
  ipr_levels_type levels;
  logic [15:0] img [8]; // shadow of what each register should hold
  int err_total, num_checks, cycles;
  // rows: address, write data, expected readback
  logic [39:0] rows [12] = '{40'h00_ffff_7707, 40'h00_2b6d_2305, 40'h04_ffff_7777,
    40'h04_2b6d_2365, 40'h08_ffff_7777, 40'h08_2b6d_2365, 40'h0c_ffff_0007,
    40'h0c_2b6d_0005, 40'h10_ffff_0070, 40'h10_2b6d_0060, 40'h14_ffff_0770,
    40'h14_2b6d_0360};
  ////////////////////////////////////////
  ipr_bank i_dut (.core_clk(core_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .src_req(src_req), .levels(levels),
    .src_pending(pend));
  ipr_src_model i_src (.core_clk(core_clk), .rstn(rstn), .pattern(pattern),
    .src_req(src_req));
  ////////////////////////////////////////
  // clock: 8 ns period
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // expected levels packed in struct order from the shadow images
  function automatic ipr_levels_type exp_lv();
    exp_lv = {img[0][14:12], img[0][10:8], img[0][2:0], img[1][14:12], img[1][10:8],
      img[1][6:4], img[1][2:0], img[2][14:12], img[2][10:8], img[2][6:4], img[2][2:0],
      img[3][2:0], img[4][6:4], img[5][10:8], img[5][6:4]};
  endfunction : exp_lv
  // a request passes only when its level is nonzero
  function automatic ipr_src_type exp_pend(ipr_levels_type lv, ipr_src_type rq);
    for (int i = 0; i < 15; i++) begin
      exp_pend[i] = rq[i] & (lv[3*i +: 3] != 3'h0);
    end
  endfunction : exp_pend
  // one compare for every kind of value, widened to the level vector
  task automatic cmp(string nm, logic [44:0] e, logic [44:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  // classic single cycle; held until ack or err is sampled high
  task automatic wb(input logic [7:0] a, input logic w, input logic [15:0] d);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= lanes;
    adr <= a;
    wdat <= {16'h0000, d};
    do begin
      @(posedge core_clk);
    end while (ack !== 1'b1 && err !== 1'b1);
    got = rdat[15:0];
    gerr = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    #1;
  endtask : wb
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  // watchdog: the whole run needs well under this many cycles
  initial begin
    cycles = 0;
    forever begin
      @(posedge core_clk);
      cycles++;
      if (cycles > 3000) begin
        err_total++;
        give_verdict();
      end
    end
  end
  ////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h3;
    lanes = 4'h3;
    wdat = 32'h0000_0000;
    pattern = 15'h7fff;
    err_total = 0;
    num_checks = 0;
    img = '{16'h4404, 16'h4444, 16'h4444, 16'h0004, 16'h0040, 16'h0440, 16'h0, 16'h0};
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
    // reset images read back, all sources at level four
    for (int r = 0; r < 6; r++) begin
      wb(8'(r * 4), 1'b0, 16'h0000);
      cmp("reset image", img[r], got);
    end
    cmp("reset levels", {15{3'h4}}, levels);
    cmp("reset pending", 15'h7fff, pend);
    // table: write, watch the levels, read back through the mask
    foreach (rows[i]) begin
      wb(rows[i][39:32], 1'b1, rows[i][31:16]);
      img[rows[i][36:34]] = rows[i][15:0];
      cmp("levels", exp_lv(), levels);
      wb(rows[i][39:32], 1'b0, 16'h0000);
      cmp("readback", rows[i][15:0], got);
    end
    // level zero hides its source even with the request raised
    wb(8'h0c, 1'b1, 16'h0000);
    img[3] = 16'h0000;
    wb(8'h00, 1'b1, 16'h0007);
    img[0] = 16'h0007;
    cmp("gated levels", exp_lv(), levels);
    cmp("pending", exp_pend(exp_lv(), src_req), pend);
    // unmapped address answers with err and stores nothing
    wb(8'h18, 1'b1, 16'hffff);
    cmp("err flag", 1'b1, gerr);
    cmp("no stray write", exp_lv(), levels);
    // low lane alone: reg b keeps its upper fields
    lanes = 4'h1;
    wb(8'h04, 1'b1, 16'h0000);
    lanes = 4'h3;
    img[1] = img[1] & 16'hff00;
    cmp("lane levels", exp_lv(), levels);
    wb(8'h04, 1'b0, 16'h0000);
    cmp("lane readback", img[1], got);
    // a nonzero level still needs its request raised
    @(posedge core_clk);
    pattern <= 15'h0f0f;
    repeat (2) @(posedge core_clk);
    cmp("pending mix", exp_pend(exp_lv(), 15'h0f0f), pend);
    // mid-run reset brings every field back to level four
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    cmp("rereset levels", {15{3'h4}}, levels);
    img = '{16'h4404, 16'h4444, 16'h4444, 16'h0004, 16'h0040, 16'h0440, 16'h0, 16'h0};
    for (int r = 0; r < 6; r++) begin
      wb(8'(r * 4), 1'b0, 16'h0000);
      cmp("rereset image", img[r], got);
    end
    cmp("rereset pending", 15'h0f0f, pend);
    give_verdict();
  end
endmodule : ipr_bank_test
`default_nettype wire

// ===== tb/ipr_src_model.sv
// far-side model: peripheral sources raising raw requests into the bank
`timescale 1ns/1ps
`default_nettype none
module ipr_src_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // request pattern chosen by the bench
  input wire ipr_pkg::ipr_src_type pattern,
  // raw requests toward the bank
  output ipr_pkg::ipr_src_type src_req
);
  import ipr_pkg::*;
  // sources change just after an edge, like on-chip peripherals
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      src_req <= 15'h0000;
    end else begin
      src_req <= pattern;
    end
  end
endmodule : ipr_src_model
`default_nettype wire
